// File: hw/ocr_regs.sv
// Oscillator control and tuning registers behind an APB slave.
// Function
// R1: PLL output divider codes give 1..64, 256.
// R2: RC divider codes give 1..64, 256; default two.
// R3: Secondary ready flag shows stable running oscillator.
// R4: Bus divisor writable only while ready flag set.
// R5: Bus divisor 1,2,4,8; resets to eight.
// R6: PLL multiplier codes give 15..21, 24.
// R7: Current source field reports active clock code.
// R8: New source field uses same encoding.
// R9: New source loads from configuration at reset.
// R10: Switch-monitor config 1x: lock bit freezes selections.
// R11: Switch-monitor config 0x: selections never locked.
// R12: USB PLL lock flag shows lock state.
// R13: System PLL lock flag shows lock state.
// R14: Sleep select chooses sleep or idle on wait.
// R15: Clock fail flag set on monitor failure.
// R16: USB RC select picks USB clock source.
// R17: Secondary enable starts and stops oscillator.
// R18: Switch request bit self-clears when done.
// R19: Tuning register holds six-bit field, reset zero.
// R20: Unimplemented control bits ignore writes, read zero.
// R21: Clear, set, invert aliases at 4, 8, C.
// R22: Current source updates as request clears.
`timescale 1ns/1ps
module ocr_regs #(
  parameter int SWITCH_CYC = ocr_pkg::OCR_SWITCH_CYC,
  parameter int DIV_SETTLE_CYC = ocr_pkg::OCR_DIV_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] initial_source_config,
  input wire logic [1:0] switch_monitor_config,
  input wire logic [2:0] pll_output_divider_config,
  input wire logic [2:0] pll_multiplier_config,
  input wire logic [1:0] bus_clock_divisor_config,
  input wire logic secondary_osc_enable_config,
  input wire logic secondary_osc_stable,
  input wire logic system_pll_locked,
  input wire logic usb_pll_locked,
  input wire logic fail_safe_clock_monitor_fail,
  input wire logic wait_executed,
  output logic [ocr_pkg::OCR_TRIM_W-1:0] fast_rc_trim,
  output logic [2:0] current_source,
  output logic [8:0] pll_div_ratio,
  output logic [8:0] frc_div_ratio,
  output logic [3:0] bus_div_ratio,
  output logic [4:0] pll_mult_ratio,
  output logic secondary_osc_run,
  output logic usb_clk_from_frc,
  output logic enter_sleep,
  output logic enter_idle
);
  import ocr_pkg::*;
  // The bus divisor config input is unread; reset gives code 11.

  // Elaboration check: counters are 8 bits wide and need at least one cycle.
  if (SWITCH_CYC < 1 || SWITCH_CYC > 255 || DIV_SETTLE_CYC < 1 || DIV_SETTLE_CYC > 255) begin : g_chk
    $error("ocr_regs: cycle counts must lie in 1..255");
  end

  // Pin-level status inputs, two flip-flops each before use.
  logic [4:0] sync1_ff; // First stage, read only by the second stage.
  logic [4:0] sync2_ff; // Second stage, safe for logic.
  logic [4:0] raw_in; // Gathered asynchronous inputs.
  logic sosc_stable_s; // Synchronised secondary-oscillator stable.
  logic spll_lock_s; // Synchronised system PLL lock.
  logic upll_lock_s; // Synchronised USB PLL lock.
  logic fail_s; // Synchronised clock-fail detect.
  logic wait_s; // Synchronised wait-instruction strobe.
  logic wait_d_ff; // Previous wait level for edge detection.

  // Control register fields.
  logic [2:0] pll_odiv_ff; // PLL output divider code.
  logic [2:0] frc_div_ff; // RC divider code.
  logic [1:0] bus_div_ff; // Peripheral bus divisor code.
  logic [2:0] pll_mult_ff; // PLL multiplier code.
  logic [2:0] cur_src_ff; // Active clock source.
  logic [2:0] new_src_ff; // Requested clock source.
  logic lock_ff; // Clock-selection lock bit.
  logic sleep_ff; // Sleep versus idle choice.
  logic fail_ff; // Sticky clock-fail flag.
  logic usb_frc_ff; // USB clock from RC.
  logic sosc_en_ff; // Secondary oscillator enable.
  logic switch_ff; // Switch request in progress.
  logic [OCR_TRIM_W-1:0] trim_ff; // RC tuning field.
  logic [7:0] sw_cnt_ff; // Cycles left in a source switch.
  logic [7:0] div_cnt_ff; // Cycles left while the bus divisor settles.
  logic [1:0] cfg_cnt_ff; // Catches configuration fields just after reset release.

  // Bus decode.
  logic wr_en; // A write completes this cycle.
  logic hit_ctrl; // Address falls in the control register group.
  logic hit_tune; // Address falls in the tuning register group.
  logic [3:0] alias_sel; // Which alias within the group.
  logic [31:0] ctrl_rd; // Assembled control register image.
  logic [31:0] tune_rd; // Assembled tuning register image.
  logic [31:0] ctrl_nxt; // Control image after the write.
  logic [31:0] tune_nxt; // Tuning image after the write.
  logic sel_locked; // Source and PLL selections frozen.
  logic div_ready; // Bus divisor may be written.
  logic switch_done; // Switch finishes this cycle.

  assign raw_in = {wait_executed, fail_safe_clock_monitor_fail, usb_pll_locked, system_pll_locked,
                   secondary_osc_stable};

  // Synchroniser chain for every pin-level status input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else if (clk_en) begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  assign sosc_stable_s = sync2_ff[0];
  assign spll_lock_s = sync2_ff[1];
  assign upll_lock_s = sync2_ff[2];
  assign fail_s = sync2_ff[3];
  assign wait_s = sync2_ff[4];

  // APB slave: zero wait states, errors on unmapped words.
  assign pready = 1'b1;
  assign alias_sel = paddr[3:0];
  assign hit_ctrl = (paddr[7:4] == OCR_CTRL_OFS[7:4]) && (paddr[1:0] == 2'h0);
  assign hit_tune = (paddr[7:4] == OCR_TUNE_OFS[7:4]) && (paddr[1:0] == 2'h0);
  // Misaligned or unmapped words get an error and no effect.
  assign pslverr = psel && penable && !(hit_ctrl || hit_tune);
  assign wr_en = psel && penable && pwrite && clk_en && !pslverr;

  // Selections are frozen only when the monitor config is 1x and the lock bit is set.
  assign sel_locked = switch_monitor_config[1] && lock_ff; // R10 R11
  // The divisor becomes writable again once the settle count runs out.
  assign div_ready = (div_cnt_ff == 8'h00); // R4
  assign switch_done = switch_ff && (sw_cnt_ff == 8'h01);

  // Read image; unimplemented bits stay zero.
  always_comb begin
    ctrl_rd = 32'h0000_0000; // R20
    ctrl_rd[OCR_PLL_ODIV_LSB +: 3] = pll_odiv_ff;
    ctrl_rd[OCR_FRC_DIV_LSB +: 3] = frc_div_ff;
    ctrl_rd[OCR_SOSC_RDY_BIT] = sosc_en_ff && sosc_stable_s; // R3
    ctrl_rd[OCR_DIV_RDY_BIT] = div_ready; // R4
    ctrl_rd[OCR_BUS_DIV_LSB +: 2] = bus_div_ff;
    ctrl_rd[OCR_PLL_MULT_LSB +: 3] = pll_mult_ff;
    ctrl_rd[OCR_CUR_SRC_LSB +: 3] = cur_src_ff; // R7
    ctrl_rd[OCR_NEW_SRC_LSB +: 3] = new_src_ff; // R8
    ctrl_rd[OCR_LOCK_BIT] = lock_ff;
    ctrl_rd[OCR_USB_PLL_LOCK_FLAG_BIT] = upll_lock_s; // R12
    ctrl_rd[OCR_SYSTEM_PLL_LOCK_FLAG_BIT] = spll_lock_s; // R13
    ctrl_rd[OCR_SLEEP_BIT] = sleep_ff;
    ctrl_rd[OCR_FAIL_BIT] = fail_ff;
    ctrl_rd[OCR_USB_FRC_BIT] = usb_frc_ff;
    ctrl_rd[OCR_SOSC_EN_BIT] = sosc_en_ff;
    ctrl_rd[OCR_SWITCH_BIT] = switch_ff;
    tune_rd = 32'h0000_0000;
    tune_rd[OCR_TRIM_W-1:0] = trim_ff; // R19
  end

  // Alias decoding: plain write, clear, set and invert of the written ones.
  function automatic logic [31:0] ocr_alias(input logic [31:0] cur, input logic [31:0] wd,
                                            input logic [3:0] sel, input logic [31:0] wmask);
    logic [31:0] r;
    r = cur;
    unique case (sel)
      OCR_ALIAS_PLAIN: r = wd;
      OCR_ALIAS_CLR: r = cur & ~wd;
      OCR_ALIAS_SET: r = cur | wd;
      default: r = cur ^ wd;
    endcase
    return (r & wmask) | (cur & ~wmask); // R20
  endfunction

  assign ctrl_nxt = ocr_alias(ctrl_rd, pwdata, {alias_sel[3:2], 2'b00}, OCR_CTRL_WMASK); // R21
  assign tune_nxt = ocr_alias(tune_rd, pwdata, {alias_sel[3:2], 2'b00}, OCR_TUNE_WMASK); // R21

  // Read data register, loaded on the setup phase so it is valid in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      if (hit_ctrl) begin
        prdata <= ctrl_rd;
      end else if (hit_tune) begin
        prdata <= tune_rd;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Configuration-derived fields: caught one cycle after reset release, since an async
  // reset may only load constants. Later writes to the selections obey the lock; the secondary enable ignores it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_cnt_ff <= 2'h0;
      new_src_ff <= 3'h0;
      pll_odiv_ff <= 3'h0;
      pll_mult_ff <= 3'h0;
      sosc_en_ff <= 1'b0;
    end else if (clk_en) begin
      if (cfg_cnt_ff == 2'h0) begin
        cfg_cnt_ff <= 2'h1;
        new_src_ff <= initial_source_config; // R9
        pll_odiv_ff <= pll_output_divider_config;
        pll_mult_ff <= pll_multiplier_config;
        sosc_en_ff <= secondary_osc_enable_config;
      end else if (wr_en && hit_ctrl) begin
        if (!sel_locked) begin
          new_src_ff <= ctrl_nxt[OCR_NEW_SRC_LSB +: 3]; // R10 R11
          pll_odiv_ff <= ctrl_nxt[OCR_PLL_ODIV_LSB +: 3];
          pll_mult_ff <= ctrl_nxt[OCR_PLL_MULT_LSB +: 3];
        end
        sosc_en_ff <= ctrl_nxt[OCR_SOSC_EN_BIT]; // R17
      end
    end
  end

  // Current source follows configuration at start, then the completed switch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_src_ff <= 3'h0;
    end else if (clk_en) begin
      if (cfg_cnt_ff == 2'h0) begin
        cur_src_ff <= initial_source_config;
      end else if (switch_done) begin
        cur_src_ff <= new_src_ff; // R22
      end
    end
  end

  // Switch request: set by software, counted down, cleared by hardware on completion.
  // A lock does not block a switch already requested; it blocks new requests and freezes the fields.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_ff <= 1'b0;
      sw_cnt_ff <= 8'h00;
    end else if (clk_en) begin
      if (switch_done) begin
        switch_ff <= 1'b0; // R18
        sw_cnt_ff <= 8'h00;
      end else if (switch_ff) begin
        sw_cnt_ff <= sw_cnt_ff - 8'h01;
      end else if (wr_en && hit_ctrl && ctrl_nxt[OCR_SWITCH_BIT] && !sel_locked) begin
        switch_ff <= 1'b1; // R18
        sw_cnt_ff <= 8'(SWITCH_CYC);
      end
    end
  end

  // Peripheral bus divisor: writes land only while ready, then ready drops for the settle time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_div_ff <= OCR_BUS_DIV_RST; // R5
      div_cnt_ff <= 8'h00;
    end else if (clk_en) begin
      if (wr_en && hit_ctrl && div_ready && (ctrl_nxt[OCR_BUS_DIV_LSB +: 2] != bus_div_ff)) begin
        bus_div_ff <= ctrl_nxt[OCR_BUS_DIV_LSB +: 2]; // R4
        div_cnt_ff <= 8'(DIV_SETTLE_CYC);
      end else if (div_cnt_ff != 8'h00) begin
        div_cnt_ff <= div_cnt_ff - 8'h01;
      end
    end
  end

  // Plain software fields and the tuning register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frc_div_ff <= OCR_FRC_DIV_RST; // R2
      lock_ff <= 1'b0;
      sleep_ff <= 1'b0;
      usb_frc_ff <= 1'b0;
      trim_ff <= '0; // R19
    end else if (clk_en) begin
      if (wr_en && hit_ctrl) begin
        frc_div_ff <= ctrl_nxt[OCR_FRC_DIV_LSB +: 3];
        lock_ff <= ctrl_nxt[OCR_LOCK_BIT];
        sleep_ff <= ctrl_nxt[OCR_SLEEP_BIT];
        usb_frc_ff <= ctrl_nxt[OCR_USB_FRC_BIT];
      end
      if (wr_en && hit_tune) begin
        trim_ff <= tune_nxt[OCR_TRIM_W-1:0]; // R19
      end
    end
  end

  // Clock-fail flag: the monitor sets it and software may clear it; a set wins.
  // A clear meeting a new failure loses, so none is missed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_ff <= 1'b0;
    end else if (clk_en) begin
      if (fail_s) begin
        fail_ff <= 1'b1; // R15
      end else if (wr_en && hit_ctrl) begin
        fail_ff <= ctrl_nxt[OCR_FAIL_BIT];
      end
    end
  end

  // Wait strobe edge detector, used to pulse the power-mode request.
  // Resetting low matches the idle pin, so no false edge follows.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_d_ff <= 1'b0;
      enter_sleep <= 1'b0;
      enter_idle <= 1'b0;
    end else if (clk_en) begin
      wait_d_ff <= wait_s;
      enter_sleep <= wait_s && !wait_d_ff && sleep_ff; // R14
      enter_idle <= wait_s && !wait_d_ff && !sleep_ff; // R14
    end
  end

  // Outputs from registers.
  assign fast_rc_trim = trim_ff;
  assign current_source = cur_src_ff;
  assign secondary_osc_run = sosc_en_ff; // R17
  assign usb_clk_from_frc = usb_frc_ff; // R16

  // Ratio decode of the stored codes.
  ocr_ratio_decode u_dec (
    .pll_output_divider(pll_odiv_ff),
    .fast_rc_divider(frc_div_ff),
    .bus_clock_divisor(bus_div_ff),
    .pll_multiplier(pll_mult_ff),
    .pll_div_ratio(pll_div_ratio),
    .frc_div_ratio(frc_div_ratio),
    .bus_div_ratio(bus_div_ratio),
    .pll_mult_ratio(pll_mult_ratio)
  );
endmodule // ocr_regs

// File: hw/ocr_pkg.sv
// Package of offsets, field positions, reset values and timing for the oscillator control registers.
package ocr_pkg;
  // Register byte offsets (one aligned word each, alias words follow each base).
  localparam logic [7:0] OCR_CTRL_OFS = 8'h00;
  localparam logic [7:0] OCR_TUNE_OFS = 8'h10;
  // Alias offsets added to a base register: plain, clear, set, invert.
  localparam logic [3:0] OCR_ALIAS_PLAIN = 4'h0;
  localparam logic [3:0] OCR_ALIAS_CLR = 4'h4;
  localparam logic [3:0] OCR_ALIAS_SET = 4'h8;
  localparam logic [3:0] OCR_ALIAS_INV = 4'hc;
  // Control register field positions (low bit of each field).
  localparam int OCR_PLL_ODIV_LSB = 27;
  localparam int OCR_FRC_DIV_LSB = 24;
  localparam int OCR_SOSC_RDY_BIT = 22;
  localparam int OCR_DIV_RDY_BIT = 21;
  localparam int OCR_BUS_DIV_LSB = 19;
  localparam int OCR_PLL_MULT_LSB = 16;
  localparam int OCR_CUR_SRC_LSB = 12;
  localparam int OCR_NEW_SRC_LSB = 8;
  localparam int OCR_LOCK_BIT = 7;
  localparam int OCR_USB_PLL_LOCK_FLAG_BIT = 6;
  localparam int OCR_SYSTEM_PLL_LOCK_FLAG_BIT = 5;
  localparam int OCR_SLEEP_BIT = 4;
  localparam int OCR_FAIL_BIT = 3;
  localparam int OCR_USB_FRC_BIT = 2;
  localparam int OCR_SOSC_EN_BIT = 1;
  localparam int OCR_SWITCH_BIT = 0;
  // Bits that software may change by any alias of the control register.
  localparam logic [31:0] OCR_CTRL_WMASK = 32'h3f1f_079f;
  // Tuning field width and mask.
  localparam int OCR_TRIM_W = 6;
  localparam logic [31:0] OCR_TUNE_WMASK = 32'h0000_003f;
  // Reset values of writable fields that are not taken from configuration.
  localparam logic [2:0] OCR_FRC_DIV_RST = 3'h1;
  localparam logic [1:0] OCR_BUS_DIV_RST = 2'h3;
  // Cycles the bus divisor takes to settle after a change, so the ready flag drops.
  localparam int OCR_DIV_SETTLE_CYC = 8;
  // Cycles a source switch takes before it is reported complete.
  localparam int OCR_SWITCH_CYC = 4;
  // Clock source encoding shared by the current and new source fields.
  typedef enum logic [2:0] {
    OCR_SRC_FRC = 3'h0,
    OCR_SRC_FRC_PLL = 3'h1,
    OCR_SRC_PRI = 3'h2,
    OCR_SRC_PRI_PLL = 3'h3,
    OCR_SRC_SEC = 3'h4,
    OCR_SRC_LOW_POWER_INTERNAL_RC = 3'h5,
    OCR_SRC_FRC_DIV16 = 3'h6,
    OCR_SRC_FRC_DIVN = 3'h7
  } ocr_src_t;
endpackage

// File: hw/ocr_ratio_decode.sv
// Decoder of the divider and multiplier codes into plain ratio values.
`timescale 1ns/1ps
module ocr_ratio_decode (
  input wire logic [2:0] pll_output_divider,
  input wire logic [2:0] fast_rc_divider,
  input wire logic [1:0] bus_clock_divisor,
  input wire logic [2:0] pll_multiplier,
  output logic [8:0] pll_div_ratio,
  output logic [8:0] frc_div_ratio,
  output logic [3:0] bus_div_ratio,
  output logic [4:0] pll_mult_ratio
);
  // Power-of-two ladder with the last step jumping to 256, shared by two dividers.
  function automatic logic [8:0] ocr_pow_div(input logic [2:0] code);
    logic [8:0] r;
    r = 9'h001;
    if (code == 3'h7) begin
      r = 9'h100;
    end else begin
      r = 9'(9'h001 << code);
    end
    return r;
  endfunction

  // Output divider of the PLL.
  assign pll_div_ratio = ocr_pow_div(pll_output_divider); // R1
  // Divider of the fast internal RC.
  assign frc_div_ratio = ocr_pow_div(fast_rc_divider); // R2
  // Bus divisor is a plain power of two up to eight.
  assign bus_div_ratio = 4'(4'h1 << bus_clock_divisor); // R5

  // Multiplier ladder runs 15 to 21, then jumps to 24.
  always_comb begin
    if (pll_multiplier == 3'h7) begin
      pll_mult_ratio = 5'h18; // R6
    end else begin
      pll_mult_ratio = 5'(5'h0f + 5'(pll_multiplier)); // R6
    end
  end
endmodule // ocr_ratio_decode

// File: verification/ocr_regs_chk.sv
// Concurrent checker for the oscillator control registers, bound to the register block.
`timescale 1ns/1ps
module ocr_regs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wait_executed,
  input wire logic [8:0] pll_div_ratio,
  input wire logic [8:0] frc_div_ratio,
  input wire logic [3:0] bus_div_ratio,
  input wire logic [4:0] pll_mult_ratio,
  input wire logic secondary_osc_run,
  input wire logic usb_clk_from_frc,
  input wire logic enter_sleep,
  input wire logic enter_idle
);
  // All checks live in the single bus clock domain.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of a read of the plain control word or of the tuning word.
  wire rd_ctrl = psel && penable && !pwrite && (paddr == 8'h00);
  wire rd_tune = psel && penable && !pwrite && (paddr == 8'h10);
  // Divide ratios are powers of two; 128 is skipped by the dividers; the multiplier ratio is 15..21 or 24.
  property p_pll_div; $onehot(pll_div_ratio) && !pll_div_ratio[7]; endproperty
  a_pll_div: assert property (p_pll_div) else $error("pll divide ratio illegal");
  property p_frc_div; $onehot(frc_div_ratio) && !frc_div_ratio[7]; endproperty
  a_frc_div: assert property (p_frc_div) else $error("rc divide ratio illegal");
  property p_bus_div; $onehot(bus_div_ratio); endproperty
  a_bus_div: assert property (p_bus_div) else $error("bus divide ratio illegal");
  property p_mult; pll_mult_ratio inside {[5'h0f:5'h15], 5'h18}; endproperty
  a_mult: assert property (p_mult) else $error("multiplier ratio illegal");
  // A wait request must give exactly one of sleep or idle, as a single pulse.
  property p_wait_mode; $rose(wait_executed) |-> ##[1:4] (enter_sleep ^ enter_idle); endproperty
  a_wait_mode: assert property (p_wait_mode) else $error("wait gave no single mode entry");
  property p_mode_pulse; (enter_sleep || enter_idle) |=> !(enter_sleep || enter_idle); endproperty
  a_mode_pulse: assert property (p_mode_pulse) else $error("mode entry not a pulse");
  property p_reserved; rd_ctrl |-> (prdata & 32'hc080_8800) == 32'h0; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved control bits nonzero");
  property p_tune_upper; rd_tune |-> prdata[31:6] == 26'h0; endproperty
  a_tune_upper: assert property (p_tune_upper) else $error("tuning upper bits nonzero");
  // Ready can only show while the oscillator is enabled.
  property p_sosc_rdy; rd_ctrl && prdata[22] |-> prdata[1]; endproperty
  a_sosc_rdy: assert property (p_sosc_rdy) else $error("ready shown while disabled");
  property p_sosc_run; rd_ctrl |-> prdata[1] == secondary_osc_run; endproperty
  a_sosc_run: assert property (p_sosc_run) else $error("enable bit and run output differ");
  property p_usb_frc; rd_ctrl |-> prdata[2] == usb_clk_from_frc; endproperty
  a_usb_frc: assert property (p_usb_frc) else $error("usb select bit and output differ");
  property p_unmapped; psel && penable && (paddr >= 8'h20) |-> pslverr && pready; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  // Main scenarios reached.
  c_sleep: cover property (enter_sleep);
  c_idle: cover property (enter_idle);
  c_ready: cover property (rd_ctrl && prdata[22]);
endmodule // ocr_regs_chk

bind ocr_regs ocr_regs_chk u_ocr_regs_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .wait_executed, .pll_div_ratio, .frc_div_ratio, .bus_div_ratio, .pll_mult_ratio, .secondary_osc_run,
  .usb_clk_from_frc, .enter_sleep, .enter_idle);

// File: verification/ocr_regs_tb_top.sv
// Self-checking APB testbench for the oscillator control registers.
`timescale 1ns/1ps
module ocr_regs_tb_top;
  import ocr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, secondary_osc_run, usb_clk_from_frc, enter_sleep, enter_idle;
  logic [2:0] initial_source_config = 3'h5, current_source;
  logic [1:0] switch_monitor_config = 2'h2;
  logic secondary_osc_stable = 1'b0, system_pll_locked = 1'b0, usb_pll_locked = 1'b0;
  logic fail_safe_clock_monitor_fail = 1'b0, wait_executed = 1'b0;
  logic [5:0] fast_rc_trim;
  logic [8:0] pll_div_ratio, frc_div_ratio;
  logic [3:0] bus_div_ratio;
  logic [4:0] pll_mult_ratio;
  int bad_count = 0, comparisons = 0;
  // Expected ratio per code.
  logic [8:0] div_tab [8] = '{9'd1, 9'd2, 9'd4, 9'd8, 9'd16, 9'd32, 9'd64, 9'd256};
  logic [4:0] mul_tab [8] = '{5'd15, 5'd16, 5'd17, 5'd18, 5'd19, 5'd20, 5'd21, 5'd24};
  logic [3:0] bus_tab [4] = '{4'd1, 4'd2, 4'd4, 4'd8};
  logic [31:0] r;
  logic er;

  // 200 MHz bus clock.
  always #2.5 pclk = ~pclk;

  // Static configuration levels are tied; they only matter at reset release.
  ocr_regs u_ocr_regs (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .initial_source_config, .switch_monitor_config, .pll_output_divider_config(3'h7),
    .pll_multiplier_config(3'h7), .bus_clock_divisor_config(2'h0), .secondary_osc_enable_config(1'b0),
    .secondary_osc_stable, .system_pll_locked, .usb_pll_locked, .fail_safe_clock_monitor_fail, .wait_executed,
    .fast_rc_trim, .current_source, .pll_div_ratio, .frc_div_ratio, .bus_div_ratio, .pll_mult_ratio,
    .secondary_osc_run, .usb_clk_from_frc, .enter_sleep, .enter_idle);

  // Compares one value and reports at once.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; entered just after a rising edge, waits on pready; the watchdog bounds it.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rv,
                     output logic ev);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle edge between calls.
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask

  // Reads a word and compares the bits under the mask.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    logic [31:0] x;
    logic y;
    apb(1'b0, a, 32'h0, x, y);
    chk(nm, e, x & m);
  endtask

  // Polls one control bit until it reaches the wanted level, under a bound.
  task automatic poll(input int b, input logic v);
    logic [31:0] x;
    logic y;
    int n;
    n = 0;
    apb(1'b0, 8'h00, 32'h0, x, y);
    while (x[b] !== v && n < 40) begin
      n++;
      apb(1'b0, 8'h00, 32'h0, x, y);
    end
    chk("poll", {31'h0, v}, {31'h0, x[b]});
  endtask

  // Raises the wait line once; records which mode entry pulses, at falling edges.
  task automatic waitev(input logic sl);
    logic s, i;
    s = 1'b0;
    i = 1'b0;
    wait_executed <= 1'b1;
    repeat (8) begin
      @(negedge pclk);
      s = s | (enter_sleep === 1'b1);
      i = i | (enter_idle === 1'b1);
    end
    @(posedge pclk);
    wait_executed <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("sleep_idle", {30'h0, sl, !sl}, {30'h0, s, i});
  endtask

  // Control word with divider, multiplier and bus codes; new source kept at five.
  function automatic logic [31:0] mk(input logic [2:0] c, input logic [1:0] b);
    mk = {2'h0, c, c, 3'h0, b, c, 8'h05, 8'h00};
  endfunction

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under ten thousand cycles.
  initial begin
    #50000;
    bad_count++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(8'h00, 32'hffff_ffff, 32'h393f_5500, "ctrl_reset");
    chk("cur_src", 32'h5, {29'h0, current_source});
    rd(8'h10, 32'hffff_ffff, 32'h0, "tune_reset");
    apb(1'b0, 8'h20, 32'h0, r, er);
    chk("slverr", 32'h1, {31'h0, er});
    // Every divider and multiplier code.
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, mk(3'(i), 2'h3));
      chk("pll_div", {23'h0, div_tab[i]}, {23'h0, pll_div_ratio});
      chk("frc_div", {23'h0, div_tab[i]}, {23'h0, frc_div_ratio});
      chk("pll_mult", {27'h0, mul_tab[i]}, {27'h0, pll_mult_ratio});
    end
    // Bus divisor codes; a write during settling must be dropped.
    for (int b = 0; b < 3; b++) begin
      wr(8'h00, mk(3'h7, 2'(b)));
      rd(8'h00, 32'h0020_0000, 32'h0, "div_busy");
      wr(8'h00, mk(3'h7, 2'h3));
      poll(OCR_DIV_RDY_BIT, 1'b1);
      chk("bus_div", {28'h0, bus_tab[b]}, {28'h0, bus_div_ratio});
    end
    wr(8'h00, mk(3'h7, 2'h3));
    poll(OCR_DIV_RDY_BIT, 1'b1);
    chk("bus_div3", 32'h8, {28'h0, bus_div_ratio});
    // Set alias, reserved bits included; then invert.
    wr(8'h08, 32'hc080_8816);
    rd(8'h00, 32'hc080_8816, 32'h0000_0016, "set_alias");
    chk("usb_frc", 32'h1, {31'h0, usb_clk_from_frc});
    chk("sosc_run", 32'h1, {31'h0, secondary_osc_run});
    wr(8'h0c, 32'h0000_0004);
    chk("usb_inv", 32'h0, {31'h0, usb_clk_from_frc});
    // Status flags follow their inputs.
    secondary_osc_stable <= 1'b1;
    system_pll_locked <= 1'b1;
    usb_pll_locked <= 1'b1;
    fail_safe_clock_monitor_fail <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(8'h00, 32'h0040_0068, 32'h0040_0068, "status");
    fail_safe_clock_monitor_fail <= 1'b0;
    system_pll_locked <= 1'b0;
    usb_pll_locked <= 1'b0;
    repeat (4) @(posedge pclk);
    wr(8'h04, 32'h0000_000a);
    repeat (4) @(posedge pclk);
    rd(8'h00, 32'h0040_006a, 32'h0, "status_off");
    // Wait request: sleep, then idle.
    waitev(1'b1);
    wr(8'h04, 32'h0000_0010);
    waitev(1'b0);
    // Tuning register and its aliases.
    wr(8'h18, 32'hffff_ffff);
    rd(8'h10, 32'hffff_ffff, 32'h3f, "tune_set");
    wr(8'h14, 32'h0000_000f);
    wr(8'h1c, 32'h0000_0003);
    rd(8'h10, 32'hffff_ffff, 32'h33, "tune_inv");
    chk("trim", 32'h33, {26'h0, fast_rc_trim});
    // Source switch to the primary oscillator.
    wr(8'h04, 32'h0000_0700);
    wr(8'h08, 32'h0000_0201);
    rd(8'h00, 32'h0000_0001, 32'h1, "switch_busy");
    poll(OCR_SWITCH_BIT, 1'b0);
    chk("cur_src_sw", 32'h2, {29'h0, current_source});
    // Locked selections refuse changes.
    wr(8'h08, 32'h0000_0080);
    wr(8'h08, 32'h0000_0100);
    wr(8'h04, 32'h0007_0000);
    rd(8'h00, 32'h0000_0780, 32'h0000_0280, "locked");
    chk("mult_locked", 32'h18, {27'h0, pll_mult_ratio});
    // Second reset with monitoring enabled: lock has no effect.
    presetn <= 1'b0;
    switch_monitor_config <= 2'h0;
    initial_source_config <= 3'h1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("cur_src_rst", 32'h1, {29'h0, current_source});
    wr(8'h08, 32'h0000_0080);
    wr(8'h08, 32'h0000_0200);
    rd(8'h00, 32'h0000_0700, 32'h0000_0300, "unlocked");
    conclude();
  end
endmodule // ocr_regs_tb_top
